/* hw/tk_setup.sv */
`timescale 1ns/100ps
`include "tk_defs.svh"

module tk_setup #(
    parameter int TICK_CYCLES = `TK_TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic put_mode_in,
    input wire logic [15:0] scope_mask_in,
    input wire logic [3:0] scope_low_key_in,
    input wire logic [15:0] pos_cross_in,
    input wire logic [15:0] neg_cross_in,
    input wire logic [15:0] burst_nonzero_in,
    input wire logic [15:0] ref_level_in,
    output logic [3:0] ref_key_out,
    output logic tx_valid_out,
    output logic [7:0] tx_byte_out,
    output logic [15:0] recal_out,
    output logic [15:0] key_error_out,
    output logic [15:0] neighbour_suppression_out,
    output logic [3:0] pulse_spacing_out,
    output logic lock_busy_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic tk_pkg::tk_byte_t round_delay(input tk_pkg::tk_byte_t v);
        if (v >= 8'hff) return 8'hff;
        else if (v >= 8'haf) return 8'haf;
        else if (v >= 8'h7b) return 8'h7b;
        else if (v >= 8'h5a) return 8'h5a;
        else if (v >= 8'h3c) return 8'h3c;
        else if (v >= 8'h2d) return 8'h2d;
        else if (v >= 8'h20) return 8'h20;
        else if (v >= 8'h14) return 8'h14;
        else if (v >= 8'h0f) return 8'h0f;
        else if (v >= 8'h0a) return 8'h0a;
        else if (v >= 8'h07) return 8'h07;
        else if (v >= 8'h05) return 8'h05;
        else if (v >= 8'h03) return 8'h03;
        else return v;
    endfunction : round_delay

    // true when dev/locked exceeds band tenths of a percent
    function automatic logic band_out(input logic [15:0] far, input logic [15:0] near,
                                      input logic [15:0] locked, input tk_pkg::tk_byte_t band);
        logic [26:0] lhs;
        logic [26:0] rhs;
        lhs = 27'(far - near) * `TK_BAND_SCALE;
        rhs = 27'(locked) * 27'(band);
        return (band != `TK_BAND_RESET) && (far > near) && (lhs > rhs);
    endfunction : band_out

    // ------------------------------------------------------------
    // storage: not cleared by reset so settings persist
    // ------------------------------------------------------------
    tk_pkg::tk_byte_t pos_delay_mem [`TK_KEYS];
    tk_pkg::tk_byte_t neg_delay_mem [`TK_KEYS];
    logic [15:0] locked_ref_mem [`TK_KEYS];
    logic [15:0] suppress_en_mem;

    tk_pkg::tk_state_e state_reg;
    tk_pkg::tk_state_e state_next;
    tk_pkg::tk_byte_t cmd_reg;
    logic [31:0] tick_cnt_reg;
    logic [31:0] arg_cnt_reg;
    logic [3:0] scan_idx_reg;
    logic [3:0] lock_idx_reg;
    logic [3:0] ee_cnt_reg;
    logic [3:0] gap_reg;
    tk_pkg::tk_byte_t pos_band_reg;
    tk_pkg::tk_byte_t neg_band_reg;
    tk_pkg::tk_byte_t sum_acc_reg;
    tk_pkg::tk_byte_t checksum_reg;
    logic [15:0] err_pos_reg;
    logic [15:0] err_neg_reg;
    tk_pkg::tk_byte_t pos_cnt_reg [`TK_KEYS];
    tk_pkg::tk_byte_t neg_cnt_reg [`TK_KEYS];
    logic [15:0] recal_reg;
    logic tx_valid_reg;
    tk_pkg::tk_byte_t tx_byte_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    wire logic in_idle = (state_reg == tk_pkg::TK_IDLE);
    wire logic in_arg = (state_reg == tk_pkg::TK_ARG);
    wire logic in_lock = (state_reg == tk_pkg::TK_LOCK);
    wire logic byte_idle = cmd_valid_in && in_idle;
    wire logic byte_arg = cmd_valid_in && in_arg;
    wire logic is_lock_cmd = (cmd_reg == `TK_CMD_LOCK_REF);
    wire logic arg_timeout = in_arg && is_lock_cmd && (arg_cnt_reg == 32'(TICK_CYCLES - 1));
    wire logic two_byte_cmd = (cmd_byte_in == `TK_CMD_POS_RECAL) ||
        (cmd_byte_in == `TK_CMD_NEG_RECAL) || (cmd_byte_in == `TK_CMD_PULSE_GAP) ||
        (cmd_byte_in == `TK_CMD_POS_BAND) || (cmd_byte_in == `TK_CMD_NEG_BAND) ||
        (cmd_byte_in == `TK_CMD_SUPPRESS) || (cmd_byte_in == `TK_CMD_LOCK_REF);
    wire logic start_put = byte_idle && put_mode_in && two_byte_cmd;
    wire logic force_recal = byte_idle && put_mode_in &&
        (cmd_byte_in == `TK_CMD_RECAL);
    wire logic lock_start = byte_arg && is_lock_cmd &&
        (cmd_byte_in == `TK_NULL_BYTE) && put_mode_in;
    wire logic ee_step = in_lock && (ee_cnt_reg == `TK_EE_WRITE_CYCLES - 4'h1);
    wire logic lock_done = ee_step && (lock_idx_reg == `TK_LAST_KEY);
    wire tk_pkg::tk_byte_t rounded = round_delay(cmd_byte_in);
    wire logic gap_ok = (cmd_byte_in >= `TK_GAP_MIN) && (cmd_byte_in <= `TK_GAP_MAX);
    wire logic [15:0] put_mask = byte_arg ? scope_mask_in : 16'h0000;
    wire logic [15:0] cur_locked = locked_ref_mem[scan_idx_reg];

    // ------------------------------------------------------------
    // get replies, per-key values from lowest key of scope
    // ------------------------------------------------------------
    tk_pkg::tk_byte_t get_value;
    logic get_hit;
    always_comb begin
        get_hit = byte_idle && !put_mode_in;
        unique case (cmd_byte_in)
            `TK_CMD_POS_RECAL: get_value = pos_delay_mem[scope_low_key_in];
            `TK_CMD_NEG_RECAL: get_value = neg_delay_mem[scope_low_key_in];
            `TK_CMD_SUPPRESS: get_value = {7'h00, suppress_en_mem[scope_low_key_in]};
            `TK_CMD_PULSE_GAP: get_value = {4'h0, gap_reg};
            `TK_CMD_POS_BAND: get_value = pos_band_reg;
            `TK_CMD_NEG_BAND: get_value = neg_band_reg;
            `TK_CMD_CHECKSUM: get_value = checksum_reg;
            default: begin
                get_value = `TK_NULL_BYTE;
                get_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tk_pkg::TK_IDLE: if (start_put) state_next = tk_pkg::TK_ARG;
            tk_pkg::TK_ARG: begin
                if (lock_start) state_next = tk_pkg::TK_LOCK;
                else if (byte_arg || arg_timeout) state_next = tk_pkg::TK_IDLE;
            end
            tk_pkg::TK_LOCK: if (lock_done) state_next = tk_pkg::TK_IDLE;
            default: state_next = tk_pkg::TK_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= tk_pkg::TK_IDLE;
            cmd_reg <= `TK_NULL_BYTE;
            arg_cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (start_put) cmd_reg <= cmd_byte_in;
            arg_cnt_reg <= in_arg ? arg_cnt_reg + 32'h1 : 32'h0;
        end
    end

    // echo follows the operand; lock echo waits for the last write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_valid_reg <= 1'b0;
            tx_byte_reg <= `TK_NULL_BYTE;
        end else begin
            tx_valid_reg <= 1'b0;
            if (get_hit) begin
                tx_valid_reg <= 1'b1;
                tx_byte_reg <= get_value;
            end else if (force_recal) begin
                tx_valid_reg <= 1'b1;
                tx_byte_reg <= `TK_CMD_RECAL;
            end else if (byte_arg && !is_lock_cmd) begin
                tx_valid_reg <= 1'b1;
                tx_byte_reg <= cmd_reg;
            end else if (lock_done) begin
                tx_valid_reg <= 1'b1;
                tx_byte_reg <= `TK_CMD_LOCK_REF;
            end
        end
    end

    // ------------------------------------------------------------
    // global settings
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gap_reg <= `TK_GAP_RESET;
            pos_band_reg <= `TK_BAND_RESET;
            neg_band_reg <= `TK_BAND_RESET;
        end else if (byte_arg) begin
            if (cmd_reg == `TK_CMD_PULSE_GAP && gap_ok) gap_reg <= cmd_byte_in[3:0];
            if (cmd_reg == `TK_CMD_POS_BAND) pos_band_reg <= cmd_byte_in;
            if (cmd_reg == `TK_CMD_NEG_BAND) neg_band_reg <= cmd_byte_in;
        end
    end

    // ------------------------------------------------------------
    // per-key storage writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        for (int k = 0; k < `TK_KEYS; k++) begin
            if (put_mask[k]) begin
                if (cmd_reg == `TK_CMD_POS_RECAL) pos_delay_mem[k] <= rounded;
                if (cmd_reg == `TK_CMD_NEG_RECAL) neg_delay_mem[k] <= rounded;
                if (cmd_reg == `TK_CMD_SUPPRESS && cmd_byte_in[7:1] == 7'h00) begin
                    suppress_en_mem[k] <= cmd_byte_in[0];
                end
            end
        end
        if (ee_step) locked_ref_mem[lock_idx_reg] <= ref_level_in;
    end

    // ------------------------------------------------------------
    // lock walk: one slow write per key, all keys regardless of scope
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lock_idx_reg <= 4'h0;
            ee_cnt_reg <= 4'h0;
        end else if (in_lock) begin
            ee_cnt_reg <= ee_step ? 4'h0 : ee_cnt_reg + 4'h1;
            if (ee_step) lock_idx_reg <= lock_idx_reg + 4'h1;
        end else begin
            lock_idx_reg <= 4'h0;
            ee_cnt_reg <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // reference scan: boundary flags and checksum
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scan_idx_reg <= 4'h0;
            err_pos_reg <= 16'h0000;
            err_neg_reg <= 16'h0000;
            sum_acc_reg <= `TK_NULL_BYTE;
            checksum_reg <= `TK_NULL_BYTE;
        end else if (!in_lock) begin
            scan_idx_reg <= scan_idx_reg + 4'h1;
            err_pos_reg[scan_idx_reg] <= band_out(ref_level_in, cur_locked, cur_locked,
                pos_band_reg);
            err_neg_reg[scan_idx_reg] <= band_out(cur_locked, ref_level_in, cur_locked,
                neg_band_reg);
            if (scan_idx_reg == `TK_LAST_KEY) begin
                checksum_reg <= sum_acc_reg + pos_delay_mem[scan_idx_reg] +
                    neg_delay_mem[scan_idx_reg] + cur_locked[7:0] + cur_locked[15:8];
                sum_acc_reg <= `TK_NULL_BYTE;
            end else begin
                sum_acc_reg <= sum_acc_reg + pos_delay_mem[scan_idx_reg] +
                    neg_delay_mem[scan_idx_reg] + cur_locked[7:0] + cur_locked[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // recalibration delays, counted in whole ticks
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    // a forced recalibration clears both timers, so a repeat restarts cleanly
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            recal_reg <= 16'h0000;
            for (int k = 0; k < `TK_KEYS; k++) begin
                pos_cnt_reg[k] <= `TK_NULL_BYTE;
                neg_cnt_reg[k] <= `TK_NULL_BYTE;
            end
        end else begin
            for (int k = 0; k < `TK_KEYS; k++) begin
                recal_reg[k] <= 1'b0;
                if (force_recal && scope_mask_in[k]) begin
                    recal_reg[k] <= 1'b1;
                    pos_cnt_reg[k] <= `TK_NULL_BYTE;
                    neg_cnt_reg[k] <= `TK_NULL_BYTE;
                end else begin
                    if (!pos_cross_in[k] || pos_delay_mem[k] == `TK_NULL_BYTE) begin
                        pos_cnt_reg[k] <= `TK_NULL_BYTE;
                    end else if (tick) begin
                        if (pos_cnt_reg[k] + 8'h01 >= pos_delay_mem[k]) begin
                            recal_reg[k] <= 1'b1;
                            pos_cnt_reg[k] <= `TK_NULL_BYTE;
                        end else begin
                            pos_cnt_reg[k] <= pos_cnt_reg[k] + 8'h01;
                        end
                    end
                    if (!neg_cross_in[k] || neg_delay_mem[k] == `TK_NULL_BYTE) begin
                        neg_cnt_reg[k] <= `TK_NULL_BYTE;
                    end else if (tick) begin
                        if (neg_cnt_reg[k] + 8'h01 >= neg_delay_mem[k]) begin
                            recal_reg[k] <= 1'b1;
                            neg_cnt_reg[k] <= `TK_NULL_BYTE;
                        end else begin
                            neg_cnt_reg[k] <= neg_cnt_reg[k] + 8'h01;
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ref_key_out = in_lock ? lock_idx_reg : scan_idx_reg;
    assign tx_valid_out = tx_valid_reg;
    assign tx_byte_out = tx_byte_reg;
    assign recal_out = recal_reg;
    assign key_error_out = err_pos_reg | err_neg_reg;
    assign neighbour_suppression_out = suppress_en_mem & burst_nonzero_in;
    assign pulse_spacing_out = gap_reg;
    assign lock_busy_out = in_lock;

endmodule : tk_setup

/* hw/tk_defs.svh */
`ifndef TK_DEFS_SVH
`define TK_DEFS_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define TK_CMD_POS_RECAL 8'h0b
`define TK_CMD_NEG_RECAL 8'h0c
`define TK_CMD_PULSE_GAP 8'h0d
`define TK_CMD_POS_BAND 8'h0e
`define TK_CMD_NEG_BAND 8'h0f
`define TK_CMD_SUPPRESS 8'h10
`define TK_CMD_CHECKSUM 8'h36
`define TK_CMD_LOCK_REF 8'h4c
`define TK_CMD_RECAL 8'h62
`define TK_NULL_BYTE 8'h00

// ------------------------------------------------------------
// operand limits and reset values
// ------------------------------------------------------------
`define TK_GAP_MIN 8'h01
`define TK_GAP_MAX 8'h0a
`define TK_GAP_RESET 4'h1
`define TK_BAND_RESET 8'h00
`define TK_BAND_SCALE 27'h00003e8
`define TK_KEYS 16
`define TK_LAST_KEY 4'hf

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TK_CLK_MHZ 100
`define TK_TICK_MS 100
`define TK_TICK_CYCLES (`TK_TICK_MS * 1000 * `TK_CLK_MHZ)
`define TK_EE_WRITE_CYCLES 4'h4

`endif

/* hw/tk_pkg.sv */
package tk_pkg;
    typedef enum logic [1:0] {
        TK_IDLE = 2'h0,
        TK_ARG = 2'h1,
        TK_LOCK = 2'h3
    } tk_state_e;
    typedef logic [7:0] tk_byte_t;
endpackage : tk_pkg

/* verif/tk_setup_checker.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// port checker for the setup command block
// ------------------------------------------------------------
module tk_setup_checker #(
    parameter int TICK_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic put_mode_in,
    input wire logic [15:0] scope_mask_in,
    input wire logic [3:0] scope_low_key_in,
    input wire logic [15:0] pos_cross_in,
    input wire logic [15:0] neg_cross_in,
    input wire logic [15:0] burst_nonzero_in,
    input wire logic [15:0] ref_level_in,
    input wire logic [3:0] ref_key_out,
    input wire logic tx_valid_out,
    input wire logic [7:0] tx_byte_out,
    input wire logic [15:0] recal_out,
    input wire logic [15:0] key_error_out,
    input wire logic [15:0] neighbour_suppression_out,
    input wire logic [3:0] pulse_spacing_out,
    input wire logic lock_busy_out
);
    // operand tracking; lock timeout is not modelled, so tests send the null at once
    logic arg_reg;
    logic band_reg;
    logic [7:0] code_reg;
    wire logic take = cmd_valid_in && !lock_busy_out;
    wire logic opens = put_mode_in && ((cmd_byte_in >= 8'h0b && cmd_byte_in <= 8'h10)
        || cmd_byte_in == 8'h4c);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arg_reg <= 1'b0;
            band_reg <= 1'b0;
            code_reg <= 8'h00;
        end else if (take) begin
            arg_reg <= !arg_reg && opens;
            code_reg <= arg_reg ? code_reg : cmd_byte_in;
            band_reg <= band_reg || (arg_reg && (code_reg == 8'h0e || code_reg == 8'h0f)
                && cmd_byte_in != 8'h00);
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_lock_req;
        take && arg_reg && code_reg == 8'h4c && put_mode_in && cmd_byte_in == 8'h00;
    endsequence
    sequence s_lock_done;
        lock_busy_out ##64 (tx_valid_out && tx_byte_out == 8'h4c);
    endsequence
    property p_lock_echo;
        s_lock_req |=> s_lock_done;
    endproperty
    a_lock_echo: assert property (p_lock_echo) else $error("lock echo timing wrong");
    property p_lock_quiet;
        lock_busy_out |-> !tx_valid_out;
    endproperty
    a_lock_quiet: assert property (p_lock_quiet) else $error("reply during lock");
    property p_lock_bad;
        take && arg_reg && code_reg == 8'h4c && cmd_byte_in != 8'h00
            |=> (!lock_busy_out && !tx_valid_out) [*2];
    endproperty
    a_lock_bad: assert property (p_lock_bad) else $error("bad lock not failed");
    property p_recal;
        take && !arg_reg && put_mode_in && cmd_byte_in == 8'h62 |=> tx_valid_out
            && tx_byte_out == 8'h62 && (recal_out & $past(scope_mask_in)) == $past(scope_mask_in);
    endproperty
    a_recal: assert property (p_recal) else $error("forced recal wrong");
    property p_cksum;
        take && !arg_reg && !put_mode_in && cmd_byte_in == 8'h36 |=> tx_valid_out;
    endproperty
    a_cksum: assert property (p_cksum) else $error("checksum not answered");
    property p_cksum_put;
        take && !arg_reg && put_mode_in && cmd_byte_in == 8'h36 |=> !tx_valid_out;
    endproperty
    a_cksum_put: assert property (p_cksum_put) else $error("checksum put answered");
    property p_echo;
        take && arg_reg && code_reg != 8'h4c |=> tx_valid_out && tx_byte_out == $past(code_reg);
    endproperty
    a_echo: assert property (p_echo) else $error("setup echo wrong");
    property p_gap_set;
        take && arg_reg && code_reg == 8'h0d |=> pulse_spacing_out ==
            (($past(cmd_byte_in) >= 8'h01 && $past(cmd_byte_in) <= 8'h0a)
            ? $past(cmd_byte_in[3:0]) : $past(pulse_spacing_out));
    endproperty
    a_gap_set: assert property (p_gap_set) else $error("pulse spacing update wrong");
    property p_gap_range;
        pulse_spacing_out >= 4'h1 && pulse_spacing_out <= 4'ha;
    endproperty
    a_gap_range: assert property (p_gap_range) else $error("pulse spacing out of range");
    property p_supp;
        (neighbour_suppression_out & ~burst_nonzero_in) == 16'h0000;
    endproperty
    a_supp: assert property (p_supp) else $error("idle key in suppression");
    property p_band_off;
        !band_reg |-> key_error_out == 16'h0000;
    endproperty
    a_band_off: assert property (p_band_off) else $error("error flag with bands off");
endmodule : tk_setup_checker

/* verif/tk_host.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// host model on the command link
// ------------------------------------------------------------
module tk_host (
    input wire logic clk_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_byte_out,
    output logic put_mode_out
);
    initial begin
        cmd_valid_out = 1'b0;
        cmd_byte_out = 8'h00;
        put_mode_out = 1'b0;
    end
    // byte lane inverted when idle so that nothing leans on a stale value
    task send(input logic [7:0] b, input logic put);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_byte_out = b;
        put_mode_out = put;
        @(negedge clk_in);
        cmd_valid_out = 1'b0;
        cmd_byte_out = ~b;
    endtask : send
    // second byte follows at once, well inside the window, in put mode
    // the run issues one lock with a non-null second byte, then one with the null
    task lock(input logic [7:0] second);
        send(8'h4c, 1'b1);
        send(second, 1'b1);
    endtask : lock
endmodule : tk_host

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    localparam int TICK = 20;
    localparam logic [7:0] DLY [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0a,
        8'h0f, 8'h14, 8'h20, 8'h2d, 8'h3c, 8'h5a, 8'h7b, 8'haf, 8'hff};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid, put_mode, tx_valid, lock_busy;
    logic [7:0] cmd_byte, tx_byte;
    logic [3:0] low_key = 4'h0;
    logic [3:0] ref_key, spacing;
    logic [15:0] scope_mask = 16'hffff;
    logic [15:0] pos_cross = 16'h0000;
    logic [15:0] neg_cross = 16'h0000;
    logic [15:0] burst = 16'hffff;
    logic [15:0] ref_level, recal, key_err, supp;
    logic [31:0] seed = 32'h00015fea;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int m = 0;
    always #5 clk_in = ~clk_in;
    function automatic int base(input logic [3:0] k);
        return 1000 + 16 * k;
    endfunction : base
    assign ref_level = 16'(base(ref_key) + base(ref_key) * m / 1000);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] round_dly(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 16; i++) if (DLY[i] <= v) r = DLY[i];
        return r;
    endfunction : round_dly
    function automatic logic [15:0] exp_err(input int mm, input int pb, input int nb);
        logic [15:0] e;
        int b;
        int r;
        e = 16'h0000;
        for (int k = 0; k < 16; k++) begin
            b = base(4'(k));
            r = b + b * mm / 1000;
            e[k] = (pb != 0 && (r - b) * 1000 > b * pb) || (nb != 0 && (b - r) * 1000 > b * nb);
        end
        return e;
    endfunction : exp_err
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task put(input logic [7:0] code, input logic [7:0] op);
        tk_host_inst.send(code, 1'b1);
        tk_host_inst.send(op, 1'b1);
        chk("echo", 16'({tx_valid, tx_byte}), 16'({1'b1, code}));
    endtask : put
    task get(input logic [7:0] code, output logic [7:0] v);
        tk_host_inst.send(code, 1'b0);
        chk("get valid", 16'(tx_valid), 16'h0001);
        v = tx_byte;
    endtask : get
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            conclude();
        end
    end
    tk_host tk_host_inst (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte),
        .put_mode_out(put_mode));
    tk_setup #(.TICK_CYCLES(TICK)) tk_setup_inst (.clk_in(clk_in), .rst_in(rst_in),
        .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte), .put_mode_in(put_mode),
        .scope_mask_in(scope_mask), .scope_low_key_in(low_key), .pos_cross_in(pos_cross),
        .neg_cross_in(neg_cross), .burst_nonzero_in(burst), .ref_level_in(ref_level),
        .ref_key_out(ref_key), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte),
        .recal_out(recal), .key_error_out(key_err), .neighbour_suppression_out(supp),
        .pulse_spacing_out(spacing), .lock_busy_out(lock_busy));
    initial begin
        logic [7:0] v, op, cs;
        int t;
        int ms [4];
        ms = '{60, 40, -30, -10};
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk("reset spacing", 16'(spacing), 16'h0001);
        chk("reset flags", key_err | recal | 16'({tx_valid, lock_busy}), 16'h0000);
        for (int i = 0; i < 12; i++) begin
            op = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : (i == 2) ? 8'h7a : 8'(rnd());
            put(i[0] ? 8'h0c : 8'h0b, op);
            low_key = 4'(rnd());
            get(i[0] ? 8'h0c : 8'h0b, v);
            chk("delay", 16'(v), 16'(round_dly(op)));
        end
        t = 1;
        for (int i = 0; i < 8; i++) begin
            op = (i == 0) ? 8'h0b : (i == 1) ? 8'h0a : (i == 2) ? 8'h00 : 8'(rnd() % 14);
            put(8'h0d, op);
            if (op >= 8'h01 && op <= 8'h0a) t = int'(op);
            chk("spacing", 16'(spacing), 16'(t));
        end
        put(8'h10, 8'h00);
        chk("suppress off", supp, 16'h0000);
        scope_mask = 16'(rnd());
        burst = 16'(rnd());
        put(8'h10, 8'h01);
        put(8'h10, 8'h02);
        chk("suppress", supp, scope_mask & burst);
        get(8'h10, v);
        chk("suppress get", 16'(v), 16'(scope_mask[low_key]));
        scope_mask = 16'hffff;
        burst = 16'hffff;
        for (int dir = 0; dir < 2; dir++) begin
            put(dir ? 8'h0c : 8'h0b, 8'h03);
            if (dir == 1) neg_cross = 16'h0001; else pos_cross = 16'h0001;
            t = 0;
            while (recal[0] !== 1'b1 && t < 100) begin
                @(negedge clk_in);
                t++;
            end
            chk("recal delay", 16'(t >= 2 * TICK - 1 && t <= 3 * TICK + 2), 16'h0001);
            pos_cross = 16'h0000;
            neg_cross = 16'h0000;
            put(dir ? 8'h0c : 8'h0b, 8'h00);
            if (dir == 1) neg_cross = 16'h0001; else pos_cross = 16'h0001;
            t = 0;
            repeat (100) begin
                @(negedge clk_in);
                if (recal[0] !== 1'b0) t++;
            end
            chk("recal never", 16'(t), 16'h0000);
            pos_cross = 16'h0000;
            neg_cross = 16'h0000;
        end
        scope_mask = 16'(rnd());
        tk_host_inst.send(8'h62, 1'b1);
        chk("recal echo", 16'({tx_valid, tx_byte}), 16'h0162);
        chk("recal keys", recal, scope_mask);
        tk_host_inst.send(8'h62, 1'b0);
        chk("recal get", 16'(tx_valid), 16'h0000);
        tk_host_inst.send(8'h36, 1'b1);
        chk("checksum put", 16'(tx_valid), 16'h0000);
        scope_mask = 16'h0001;
        tk_host_inst.lock(8'h01);
        chk("bad lock", 16'({tx_valid, lock_busy}), 16'h0000);
        tk_host_inst.lock(8'h00);
        t = 0;
        while (tx_valid !== 1'b1 && t < 200) begin
            @(negedge clk_in);
            t++;
        end
        chk("lock echo", 16'({tx_valid, tx_byte}), 16'h014c);
        chk("lock wait", 16'(t >= 60), 16'h0001);
        put(8'h0e, 8'h32);
        put(8'h0f, 8'h14);
        for (int i = 0; i < 4; i++) begin
            m = ms[i];
            repeat (40) @(negedge clk_in);
            chk("band flags", key_err, exp_err(m, 50, 20));
        end
        put(8'h0e, 8'h00);
        get(8'h0e, v);
        chk("band get", 16'(v), 16'h0000);
        m = 60;
        repeat (40) @(negedge clk_in);
        chk("band off", key_err, 16'h0000);
        m = 0;
        cs = 8'h00;
        for (int k = 0; k < 16; k++) cs += 8'(base(4'(k))) + 8'(base(4'(k)) >> 8);
        get(8'h36, v);
        chk("checksum", 16'(v), 16'(cs));
        conclude();
    end
endmodule : tb_top
bind tk_setup tk_setup_checker #(.TICK_CYCLES(TICK_CYCLES)) tk_setup_checker_inst (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
    .put_mode_in(put_mode_in), .scope_mask_in(scope_mask_in), .scope_low_key_in(scope_low_key_in),
    .pos_cross_in(pos_cross_in), .neg_cross_in(neg_cross_in), .burst_nonzero_in(burst_nonzero_in),
    .ref_level_in(ref_level_in), .ref_key_out(ref_key_out), .tx_valid_out(tx_valid_out),
    .tx_byte_out(tx_byte_out), .recal_out(recal_out), .key_error_out(key_error_out),
    .neighbour_suppression_out(neighbour_suppression_out),
    .pulse_spacing_out(pulse_spacing_out), .lock_busy_out(lock_busy_out));
